//--- src/nand_host_ctrl.sv
// apb-controlled host sequencer that drives nand command, address and data cycles
`timescale 1ns/1ps
module nand_host_ctrl
  import nand_host_pkg::*;
(
  input wire logic clk_sys_in, // 40 MHz system clock
  input wire logic rst_n_in, // synchronous reset, active low
  input wire logic clk_en_in, // freezes all state while low
  input wire logic psel_in, // apb select
  input wire logic penable_in, // apb access phase
  input wire logic pwrite_in, // apb direction
  input wire logic [11:0] paddr_in, // apb byte address
  input wire logic [31:0] pwdata_in, // apb write data
  output logic pready_out, // apb ready
  output logic pslverr_out, // apb error
  output logic [31:0] prdata_out, // apb read data
  input wire logic [7:0] io_in, // flash data bus level
  input wire logic ready_busy_n_in, // flash ready/busy pin
  output nand_pins_t pins_out // flash control and data pins
);
  seq_state_t state_ff; // sequencer state
  cyc_kind_t kind_ff; // kind of bus cycle in progress
  logic [3:0] cnt_ff; // strobe phase counter
  logic [7:0] byte_ff; // byte driven in this cycle
  logic [7:0] mask_ff; // poll mask for status bits
  logic [7:0] rdata_ff; // last byte read from the flash
  logic [CFG_W-1:0] cfg_ff; // select, write-protect release, interleave
  logic order_err_ff; // sticky: page order broken
  logic partial_err_ff; // sticky: too many partial programs
  logic refused_ff; // sticky: command refused
  logic prog_open_ff; // serial input seen, confirm pending
  logic [2:0] addr_idx_ff; // address cycles since last command
  logic [5:0] new_page_ff; // page captured from address cycle
  logic [5:0] last_page_ff; // last programmed page
  logic last_valid_ff; // a page has been programmed
  logic [2:0] partial_ff; // programs into last page
  logic acc; // apb access phase
  logic seq_reg; // access needs a flash cycle
  logic cmd_bad; // command write that must be refused
  logic start; // launch a flash cycle
  logic [7:0] wbyte; // low byte of write data
  logic poll_hit; // polled status bits reached
  nand_pins_t pins_ff; // combinational pin values

  assign acc = psel_in && penable_in;
  assign wbyte = pwdata_in[7:0];
  assign seq_reg = (paddr_in == REG_CMD && pwrite_in) || paddr_in == REG_ADDR || paddr_in == REG_DATA
                   || (paddr_in == REG_POLL && pwrite_in);
  // busy flash takes only status or reset; interleaved dies need 78h
  // a poll also opens with plain 70h, so it is refused under interleave as well
  assign cmd_bad = pwrite_in
                   && ((paddr_in == REG_CMD && !ready_busy_n_in && wbyte != CMD_STATUS && wbyte != CMD_RESET) // see [R16]
                       || (cfg_ff[CFG_INTERLEAVE]
                           && (paddr_in == REG_POLL || (paddr_in == REG_CMD && wbyte == CMD_STATUS)))); // see [R4]
  assign start = clk_en_in && acc && seq_reg && !cmd_bad && state_ff == ST_IDLE;
  assign poll_hit = (io_in & mask_ff) != 8'h00;

  // apb answer: flash cycles wait for done, others answer at once
  always_comb begin
    pready_out = 1'b1;
    if (acc && seq_reg && !cmd_bad) begin
      pready_out = state_ff == ST_DONE; // held until the cycle completes
    end
  end
  assign pslverr_out = acc && (cmd_bad || !(seq_reg || paddr_in == REG_CFG || paddr_in == REG_STAT));

  // read mux
  always_comb begin
    prdata_out = 32'h0000_0000;
    case (paddr_in)
      REG_DATA, REG_POLL: prdata_out[7:0] = rdata_ff;
      REG_CFG: prdata_out[CFG_W-1:0] = cfg_ff;
      REG_STAT: begin
        prdata_out[7:0] = rdata_ff;
        prdata_out[ST_RB] = ready_busy_n_in;
        prdata_out[ST_ORDER_ERR] = order_err_ff;
        prdata_out[ST_PARTIAL_ERR] = partial_err_ff;
        prdata_out[ST_REFUSED] = refused_ff;
      end
      default: prdata_out = 32'h0000_0000;
    endcase
  end

  // strobe sequencer: low phase, high phase, optional status poll
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_ff <= ST_IDLE;
      kind_ff <= K_CMD;
      cnt_ff <= 4'h0;
      byte_ff <= 8'h00;
      mask_ff <= 8'h00;
      rdata_ff <= 8'h00;
    end else if (clk_en_in) begin
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            state_ff <= ST_LOW;
            cnt_ff <= STROBE_LAST;
            byte_ff <= wbyte;
            mask_ff <= wbyte;
            if (paddr_in == REG_POLL) begin
              kind_ff <= K_POLL; // issues 70h first
              byte_ff <= CMD_STATUS;
            end else if (paddr_in == REG_CMD) begin
              kind_ff <= K_CMD; // see [R14]
            end else if (paddr_in == REG_ADDR) begin
              kind_ff <= K_ADDR;
            end else if (pwrite_in) begin
              kind_ff <= K_WR; // data byte goes to the current column, see [R18]
            end else begin
              kind_ff <= K_RD;
            end
          end
        end
        ST_LOW: begin
          if (cnt_ff == 4'h0) begin
            if (kind_ff == K_RD) begin
              rdata_ff <= io_in; // sampled at the end of the low phase
            end
            state_ff <= ST_HIGH;
            cnt_ff <= STROBE_LAST;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        ST_HIGH: begin
          if (cnt_ff != 4'h0) begin
            cnt_ff <= cnt_ff - 4'h1;
          end else if (kind_ff == K_POLL) begin
            state_ff <= ST_POLL; // read strobe held low, status follows live
          end else begin
            state_ff <= ST_DONE;
          end
        end
        ST_POLL: begin
          rdata_ff <= io_in; // see [R2]
          if (poll_hit) begin
            kind_ff <= K_RD; // see [R22]
            state_ff <= ST_HIGH;
            cnt_ff <= STROBE_LAST;
          end
        end
        ST_DONE: state_ff <= ST_IDLE;
        default: state_ff <= ST_IDLE;
      endcase
    end
  end

  // configuration register
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cfg_ff <= '0;
    end else if (clk_en_in && acc && pwrite_in && paddr_in == REG_CFG) begin
      cfg_ff <= pwdata_in[CFG_W-1:0];
    end
  end

  // page order and partial program tracking; a set beats a clear
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      order_err_ff <= 1'b0;
      partial_err_ff <= 1'b0;
      refused_ff <= 1'b0;
      prog_open_ff <= 1'b0;
      addr_idx_ff <= 3'h0;
      new_page_ff <= 6'h00;
      last_page_ff <= 6'h00;
      last_valid_ff <= 1'b0;
      partial_ff <= 3'h0;
    end else if (clk_en_in) begin
      if (acc && pwrite_in && paddr_in == REG_STAT) begin
        order_err_ff <= order_err_ff & ~pwdata_in[ST_ORDER_ERR];
        partial_err_ff <= partial_err_ff & ~pwdata_in[ST_PARTIAL_ERR];
        refused_ff <= refused_ff & ~pwdata_in[ST_REFUSED];
      end
      if (acc && cmd_bad && state_ff == ST_IDLE) begin
        refused_ff <= 1'b1; // see [R16]
      end
      if (start && paddr_in == REG_CMD) begin
        addr_idx_ff <= 3'h0;
        if (wbyte == CMD_SERIAL) begin
          prog_open_ff <= 1'b1;
        end else if (prog_open_ff && (wbyte == CMD_CONFIRM || wbyte == CMD_CACHE)) begin
          prog_open_ff <= 1'b0;
          last_page_ff <= new_page_ff;
          last_valid_ff <= 1'b1;
          if (last_valid_ff && new_page_ff == last_page_ff) begin
            partial_ff <= partial_ff + 3'h1;
            if (partial_ff >= MAX_PARTIAL) begin // four programs allowed, the fifth is flagged
              partial_err_ff <= 1'b1; // see [R13]
            end
          end else begin
            partial_ff <= 3'h1;
            // page 0 starts a new block; staying on one die is left to software, see [R21]
            if (last_valid_ff && new_page_ff != 6'h00 && new_page_ff != last_page_ff + 6'h01) begin
              order_err_ff <= 1'b1; // see [R12]
            end
          end
        end
      end
      if (start && paddr_in == REG_ADDR && addr_idx_ff != ADDR_CYCLES) begin
        addr_idx_ff <= addr_idx_ff + 3'h1;
        if (addr_idx_ff == PAGE_CYCLE && prog_open_ff) begin
          new_page_ff <= wbyte[5:0] & PAGE_MASK;
        end
      end
    end
  end

  // pin drive: latch enables and bus set up with the low phase
  always_comb begin
    pins_ff.ce_n = !cfg_ff[CFG_SELECT];
    pins_ff.wp_n = cfg_ff[CFG_WP_OFF];
    pins_ff.cle = (state_ff == ST_LOW || state_ff == ST_HIGH) && (kind_ff == K_CMD || kind_ff == K_POLL);
    pins_ff.ale = (state_ff == ST_LOW || state_ff == ST_HIGH) && kind_ff == K_ADDR;
    pins_ff.we_n = !(state_ff == ST_LOW && kind_ff != K_RD);
    pins_ff.read_strobe_n = !((state_ff == ST_LOW && kind_ff == K_RD) || state_ff == ST_POLL);
    pins_ff.io_oe_n = !((state_ff == ST_LOW || state_ff == ST_HIGH) && kind_ff != K_RD);
    pins_ff.io = byte_ff;
  end
  assign pins_out = pins_ff;

  // checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  property p_busy_cmd;
    clk_en_in && state_ff == ST_IDLE && !ready_busy_n_in && acc && pwrite_in && paddr_in == REG_CMD
      && wbyte != CMD_STATUS && wbyte != CMD_RESET |-> !start && pslverr_out;
  endproperty
  a_busy_cmd: assert property (p_busy_cmd) else $error("busy flash given a command"); // see [R16]
  property p_no_plain_status;
    cfg_ff[CFG_INTERLEAVE] |-> !(pins_out.cle && !pins_out.we_n && byte_ff == CMD_STATUS);
  endproperty
  a_no_plain_status: assert property (p_no_plain_status) else $error("plain status with interleave"); // see [R4]
  property p_poll_strobe;
    state_ff == ST_POLL && !poll_hit && clk_en_in |=> !pins_out.read_strobe_n;
  endproperty
  a_poll_strobe: assert property (p_poll_strobe) else $error("read strobe released early"); // see [R2]
  property p_poll_end;
    clk_en_in && state_ff == ST_POLL && poll_hit |=> state_ff == ST_HIGH && rdata_ff == $past(io_in);
  endproperty
  a_poll_end: assert property (p_poll_end) else $error("poll did not end on status"); // see [R22]
  property p_order;
    clk_en_in && start && paddr_in == REG_CMD && wbyte == CMD_CONFIRM && prog_open_ff && last_valid_ff
      && new_page_ff != 6'h00 && new_page_ff != last_page_ff && new_page_ff != last_page_ff + 6'h01
      |=> order_err_ff;
  endproperty
  a_order: assert property (p_order) else $error("page order error missed"); // see [R12]
  property p_partial;
    clk_en_in && start && paddr_in == REG_CMD && wbyte == CMD_CONFIRM && prog_open_ff && last_valid_ff
      && new_page_ff == last_page_ff && partial_ff == MAX_PARTIAL |=> partial_err_ff;
  endproperty
  a_partial: assert property (p_partial) else $error("fifth partial program missed"); // see [R13]
  property p_cycle_len;
    clk_en_in && start && paddr_in != REG_POLL ##1 clk_en_in [*2] |=> state_ff == ST_DONE;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("bus cycle length wrong"); // see [R14]
  property p_latch_excl;
    !(pins_out.cle && pins_out.ale) && !(pins_out.io_oe_n == 1'b0 && !pins_out.read_strobe_n);
  endproperty
  a_latch_excl: assert property (p_latch_excl) else $error("bus contention on pins"); // see [R18]
  property p_status_cmd_ready;
    clk_en_in && start && paddr_in == REG_CMD |-> ##[1:4] pready_out;
  endproperty
  a_status_cmd_ready: assert property (p_status_cmd_ready) else $error("command not answered"); // see [R5]

  c_program: cover property (start && paddr_in == REG_CMD && wbyte == CMD_CONFIRM);
  c_cache: cover property (start && paddr_in == REG_CMD && wbyte == CMD_CACHE);
  c_poll: cover property (state_ff == ST_POLL ##1 state_ff == ST_HIGH);
  c_refused: cover property (refused_ff);
endmodule // nand_host_ctrl

//--- src/nand_host_pkg.sv
// constants, types and register map of the nand host sequencer
// Behaviour
// [R1] device returns status until a new command
// [R2] status changes appear while strobes stay low
// [R3] plain status reports last addressed die
// [R4] interleaved dies need 78h, never plain 70h
// [R5] reissue read command after status polling
// [R6] status bit 0 is program/erase pass/fail
// [R7] bit 1 is previous cached page result
// [R8] status bits 2 to 4 read zero
// [R9] bit 5 low while array programs
// [R10] bit 6 is cache ready, pin follows
// [R11] bit 7 low when write protected
// [R12] program pages ascending within a block
// [R13] at most four partial programs per page
// [R14] 80h, five address cycles, data, confirm
// [R15] busy pin low during internal program
// [R16] only status or reset while busy
// [R17] status mode persists after program
// [R18] 85h plus column redirects data input
// [R19] 15h moves cache to data register
// [R20] later cache transfers wait for array
// [R21] cached sequence never crosses a die
// [R22] end cached run by 10h or poll bit 5
// [R23] bit 0 meaning follows bits 6 and 5
package nand_host_pkg;
  // apb register offsets
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_ADDR = 12'h004;
  localparam logic [11:0] REG_DATA = 12'h008;
  localparam logic [11:0] REG_POLL = 12'h00c;
  localparam logic [11:0] REG_CFG = 12'h010;
  localparam logic [11:0] REG_STAT = 12'h014;
  // config fields
  localparam int CFG_SELECT = 0;
  localparam int CFG_WP_OFF = 1;
  localparam int CFG_INTERLEAVE = 2;
  localparam int CFG_W = 3;
  // status register fields
  localparam int ST_RB = 8;
  localparam int ST_ORDER_ERR = 9;
  localparam int ST_PARTIAL_ERR = 10;
  localparam int ST_REFUSED = 11;
  // nand commands
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_CONFIRM = 8'h10;
  localparam logic [7:0] CMD_CACHE = 8'h15;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_DIE_STATUS = 8'h78;
  localparam logic [7:0] CMD_SERIAL = 8'h80;
  localparam logic [7:0] CMD_RANDOM = 8'h85;
  localparam logic [7:0] CMD_RESET = 8'hff;
  // address cycle carrying the page number, and program limits
  localparam logic [2:0] PAGE_CYCLE = 3'h2;
  localparam logic [2:0] ADDR_CYCLES = 3'h5;
  localparam logic [5:0] PAGE_MASK = 6'h3f;
  localparam logic [2:0] MAX_PARTIAL = 3'h4;
  // strobe timing
  localparam int CLK_NS = 25;
  localparam int STROBE_NS = 25;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [3:0] STROBE_LAST = 4'(STROBE_CYC - 1);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOW = 3'b001,
    ST_HIGH = 3'b010,
    ST_POLL = 3'b011,
    ST_DONE = 3'b100
  } seq_state_t;

  typedef enum logic [2:0] {
    K_CMD = 3'b000,
    K_ADDR = 3'b001,
    K_WR = 3'b010,
    K_RD = 3'b011,
    K_POLL = 3'b100
  } cyc_kind_t;

  // pins toward the flash; io_oe_n low while the host drives the bus
  typedef struct packed {
    logic ce_n;
    logic cle;
    logic ale;
    logic we_n;
    logic read_strobe_n;
    logic wp_n;
    logic io_oe_n;
    logic [7:0] io;
  } nand_pins_t;
endpackage

//--- test/nand_flash_model.sv
// behavioural flash device answering the host sequencer
`timescale 1ns/1ps
module nand_flash_model
  import nand_host_pkg::*;
#(
  parameter int PROG_NS = 4000, // shortened array program time
  parameter int XFER_NS = 100 // cache to data register move
) (
  input wire nand_pins_t pins_in, // host pins
  input wire logic fail_in, // outcome of next array program
  output logic [7:0] io_out, // bus level toward host
  output logic ready_busy_n_out // ready pin, low busy
);
  logic stat_ff = 1'h0; // reads return status
  logic cache_rdy_ff = 1'h1; // cache accepts data
  logic array_rdy_ff = 1'h1; // array idle
  logic cur_fail_ff = 1'h0; // current page result
  logic prev_fail_ff = 1'h0; // previous page result
  logic [7:0] col_ff = 8'h00; // column pointer
  logic [7:0] last_ff = 8'h00; // last value driven
  logic [2:0] addr_n_ff = 3'h0; // address cycles since command
  logic [7:0] status_byte; // single die, so every cached run stays on it
  // bit 0 shows the previous page until the array finishes
  assign status_byte = {pins_in.wp_n, cache_rdy_ff, array_rdy_ff, 3'h0, prev_fail_ff,
    array_rdy_ff ? cur_fail_ff : prev_fail_ff};
  assign ready_busy_n_out = cache_rdy_ff;
  // released bus shows the inverse of its last value: no pull resistor here
  assign io_out = (!pins_in.ce_n && !pins_in.read_strobe_n) ? (stat_ff ? status_byte : col_ff) : ~last_ff;
  always @(posedge pins_in.read_strobe_n) last_ff = stat_ff ? status_byte : col_ff;
  // program and cache moves keep their own timing
  task automatic prog(input logic cached);
    cache_rdy_ff = 1'h0;
    wait (array_rdy_ff);
    #XFER_NS;
    prev_fail_ff = cur_fail_ff;
    if (cached) cache_rdy_ff = 1'h1;
    array_rdy_ff = 1'h0;
    #PROG_NS;
    cur_fail_ff = fail_in;
    array_rdy_ff = 1'h1;
    if (!cached) cache_rdy_ff = 1'h1;
  endtask
  // commands, address and data latch on the rising write strobe
  always @(posedge pins_in.we_n) begin
    if (!pins_in.ce_n && pins_in.cle && (cache_rdy_ff || pins_in.io == CMD_STATUS || pins_in.io == CMD_RESET)) begin
      stat_ff = (pins_in.io == CMD_STATUS);
      addr_n_ff = 3'h0;
      if (pins_in.io == CMD_CONFIRM || pins_in.io == CMD_CACHE) begin
        fork
          prog(pins_in.io == CMD_CACHE);
        join_none
      end
    end else if (!pins_in.ce_n && pins_in.ale) begin
      if (addr_n_ff == 3'h0) col_ff = pins_in.io;
      addr_n_ff = addr_n_ff + 3'h1;
    end else if (!pins_in.ce_n && !pins_in.cle) begin
      col_ff = col_ff + 8'h1;
    end
  end
endmodule // nand_flash_model

//--- test/nand_host_ctrl_tb.sv
// self-checking bench for the nand host sequencer
`timescale 1ns/1ps
module nand_host_ctrl_tb;
  import nand_host_pkg::*;
  logic clk_sys_in = 1'h0; // system clock
  logic rst_n_in = 1'h0; // reset, active low
  logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0; // apb controls
  logic [11:0] paddr = 12'h000; // apb address
  logic [31:0] pwdata = 32'h0, prdata, rd_q; // apb data
  logic pready, pslverr, rd_err, rb_n; // answers
  logic fail = 1'h0; // device outcome of next program
  logic clk_en = 1'h1; // clock enable toward the block
  logic [7:0] io, dev_io; // resolved bus, device side
  nand_pins_t pins; // host pins
  int n_addr = 0; // address strobes since last command
  int n_mismatch = 0, checked = 0; // tallies
  nand_host_ctrl u_dut (
    .clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .clk_en_in(clk_en), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .pready_out(pready), .pslverr_out(pslverr), .prdata_out(prdata), .io_in(io),
    .ready_busy_n_in(rb_n), .pins_out(pins)
  );
  // device delays end between clock edges, so busy never races a sampling edge
  nand_flash_model #(.PROG_NS(4010), .XFER_NS(110)) u_flash (
    .pins_in(pins), .fail_in(fail), .io_out(dev_io), .ready_busy_n_out(rb_n)
  );
  // host owns the bus while its enable is low
  assign io = pins.io_oe_n ? dev_io : pins.io;
  initial begin
    forever #12.5 clk_sys_in = ~clk_sys_in;
  end
  // wire watch: a command restarts the address count
  always @(posedge pins.we_n) n_addr <= pins.cle ? 0 : n_addr + int'(pins.ale);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer; holds the request until pready, then one idle cycle
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_in);
    penable <= 1'h1;
    // pready, read data and error are all taken at the rising edge that completes
    do begin
      @(posedge clk_sys_in);
    end while (pready !== 1'h1);
    rd_q = prdata;
    rd_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk_sys_in);
  endtask
  // status poll until mask bits set, then compare the byte
  task automatic poll(input logic [7:0] mask, input logic [7:0] exp);
    apb(1'h1, REG_POLL, {24'h0, mask});
    apb(1'h0, REG_POLL, 32'h0);
    check({24'h0, rd_q[7:0]}, {24'h0, exp});
  endtask
  // page load with one column redirect, ending in the given command
  task automatic load(input logic [7:0] page, input logic [7:0] fin);
    apb(1'h1, REG_CMD, {24'h0, CMD_SERIAL});
    for (int i = 0; i < 5; i++) begin
      apb(1'h1, REG_ADDR, (i == 2) ? {24'h0, page} : 32'h0);
    end
    check(32'(n_addr), 32'h5);
    apb(1'h1, REG_DATA, 32'h5a);
    apb(1'h1, REG_CMD, {24'h0, CMD_RANDOM});
    apb(1'h1, REG_ADDR, 32'h10);
    apb(1'h1, REG_ADDR, 32'h0);
    check(32'(n_addr), 32'h2);
    apb(1'h1, REG_DATA, 32'ha5);
    apb(1'h1, REG_CMD, {24'h0, fin});
  endtask
  task automatic t_regs();
    apb(1'h0, 12'hffc, 32'h0);
    check({31'h0, rd_err}, 32'h1);
    // a write while the enable is low must leave no trace
    clk_en <= 1'h0;
    apb(1'h1, REG_CFG, 32'h3);
    clk_en <= 1'h1;
    apb(1'h0, REG_CFG, 32'h0);
    check(rd_q, 32'h0);
    apb(1'h1, REG_CFG, 32'h3);
    apb(1'h0, REG_CFG, 32'h0);
    check(rd_q, 32'h3);
    $display("test regs done");
  endtask
  task automatic t_program();
    load(8'h00, CMD_CONFIRM);
    apb(1'h0, REG_STAT, 32'h0);
    check({31'h0, rd_q[ST_RB]}, 32'h0);
    poll(8'h40, 8'he0);
    apb(1'h0, REG_DATA, 32'h0);
    check({24'h0, rd_q[7:0]}, 32'he0);
    fail <= 1'h1;
    load(8'h01, CMD_CONFIRM);
    poll(8'h40, 8'he1);
    apb(1'h1, REG_CFG, 32'h1);
    apb(1'h0, REG_DATA, 32'h0);
    check({24'h0, rd_q[7:0]}, 32'h61);
    apb(1'h1, REG_CFG, 32'h3);
    $display("test program done");
  endtask
  // commands while busy, and plain status with interleave on
  task automatic t_refused();
    load(8'h02, CMD_CONFIRM);
    apb(1'h1, REG_CMD, {24'h0, CMD_SERIAL});
    check({31'h0, rd_err}, 32'h1);
    apb(1'h1, REG_CMD, {24'h0, CMD_STATUS});
    check({31'h0, rd_err}, 32'h0);
    apb(1'h0, REG_STAT, 32'h0);
    check({31'h0, rd_q[ST_REFUSED]}, 32'h1);
    apb(1'h1, REG_STAT, 32'h800);
    apb(1'h1, REG_CFG, 32'h7);
    apb(1'h1, REG_CMD, {24'h0, CMD_STATUS});
    check({31'h0, rd_err}, 32'h1);
    apb(1'h1, REG_POLL, 32'h40);
    check({31'h0, rd_err}, 32'h1);
    apb(1'h1, REG_CFG, 32'h3);
    poll(8'h40, 8'he3);
    fail <= 1'h0;
    $display("test refused done");
  endtask
  // cached run: bit 0 moves from previous to current page
  task automatic t_cache();
    load(8'h03, CMD_CACHE);
    poll(8'h40, 8'hc3);
    poll(8'h20, 8'he2);
    load(8'h04, CMD_CACHE);
    poll(8'h40, 8'hc0);
    load(8'h05, CMD_CONFIRM);
    poll(8'h40, 8'he0);
    $display("test cache done");
  endtask
  task automatic t_order();
    load(8'h09, CMD_CONFIRM);
    poll(8'h40, 8'he0);
    apb(1'h0, REG_STAT, 32'h0);
    check({31'h0, rd_q[ST_ORDER_ERR]}, 32'h1);
    $display("test order done");
  endtask
  // page 9 already holds one program: three more are legal, the fifth is flagged
  task automatic t_partial();
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, REG_STAT, 32'h0);
      check({31'h0, rd_q[ST_PARTIAL_ERR]}, 32'h0);
      load(8'h09, CMD_CONFIRM);
      poll(8'h40, 8'he0);
    end
    apb(1'h0, REG_STAT, 32'h0);
    check({31'h0, rd_q[ST_PARTIAL_ERR]}, 32'h1);
    $display("test partial done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys_in);
    rst_n_in <= 1'h1;
    @(posedge clk_sys_in);
    t_regs();
    t_program();
    t_refused();
    t_cache();
    t_order();
    t_partial();
    stop_test();
  end
  // watchdog well past the expected few thousand cycles
  initial begin
    #(25 * 40000);
    n_mismatch++;
    stop_test();
  end
endmodule // nand_host_ctrl_tb
